/* File: logic/epwm_gen.sv */
// Enhanced PWM generator with Wishbone register access
// Functional notes
// - Period is (limit+1) x 4 x prescale oscillator periods
// - Limit match: clear count, set pin, load duty
// - Postscaler never affects PWM frequency
// - Duty: eight buffer MSBs plus two control LSBs
// - Duty double-buffered, active copy updated per period
// - Active duty read-only while PWM selected
// - Time base: count plus phase or prescaler bits
// - Pin cleared when time base equals duty
// - Duty above period gives no falling edge
// - Resolution is log2 of four times period
// - Sleep freezes counter, state and pin levels
// - Reset restores registers, pins become inputs
// - Mode field selects single, half, full bridges
// - Output active levels chosen by polarity bits
// - Enabling waits for a fresh period start
// - Zero control releases every output pin
// - Unused pins are never driven
// - Half bridge delays active edges by dead-band
// - Half bridge: A waveform, B its complement
// - Forward: A active, D modulated, B C off
// - Reverse: C active, B modulated, A D off
// - Polarity bits per A/C and B/D pair
//
// Added by the designer: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
module epwm_gen #(
	parameter int TIMER_W = 8
) (
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	input wire logic sleep_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [epwm_pkg::WB_AW-1:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [epwm_pkg::WB_DW-1:0] wb_dat_in,
	output logic [epwm_pkg::WB_DW-1:0] wb_dat_out,
	output logic wb_ack_out,
	output logic [3:0] pwm_level_out,
	output logic [3:0] pwm_oe_out
);
	import epwm_pkg::*;

	if (TIMER_W != 8) begin : g_check
		$error("epwm_gen: TIMER_W must be 8, the register lane width");
	end

	typedef struct packed {
		logic [TIMER_W-1:0] period_limit;
		logic [TIMER_W-1:0] base_timer_count;
		logic [TIMER_W-1:0] duty_buffer_low;
		logic [TIMER_W-1:0] duty_active;
		logic [1:0] duty_lsb;
		logic [1:0] duty_latch;
		logic [1:0] output_mode_select;
		logic [3:0] mode_polarity_select;
		logic [DB_W-1:0] dead_band_count;
		logic [1:0] timer_prescale_select;
		logic timer_run;
		logic timer_match_flag;
		logic [3:0] pin_direction;
		logic [5:0] sub;
		logic raw;
		logic started;
		logic [DB_W-1:0] db_left;
		logic [3:0] level;
		logic [3:0] oe;
		logic ack;
		logic [7:0] rdata;
	} epwm_state_s;

	epwm_state_s r;
	epwm_state_s next_r;

	// Last sub-count of one base-timer increment
	function automatic logic [5:0] epwm_sub_max(input logic [1:0] ps);
		if (ps == PS_1) begin
			return SUB_MAX_1;
		end else if (ps == PS_4) begin
			return SUB_MAX_4;
		end
		return SUB_MAX_16;
	endfunction : epwm_sub_max

	// Two extra low bits of the time base
	function automatic logic [1:0] epwm_low_bits(input logic [5:0] sub,
		input logic [1:0] ps);
		if (ps == PS_1) begin
			return sub[1:0];
		end else if (ps == PS_4) begin
			return sub[3:2];
		end
		return sub[5:4];
	endfunction : epwm_low_bits

	// Pins claimed by each output mode
	function automatic logic [3:0] epwm_pins_used(input logic [1:0] om);
		unique case (om)
			OM_SINGLE: return 4'h1;
			OM_HALF: return 4'h3;
			OM_FULL_FWD, OM_FULL_REV: return 4'hf;
		endcase
	endfunction : epwm_pins_used

	logic pwm_mode;
	logic tick;
	logic boundary;
	logic wr;
	logic rd_cycle;
	logic [TIMER_W+1:0] nxt_tb;
	logic [3:0] on;
	logic [3:0] pol_low;
	logic db_done;
	logic [3:0] used;

	assign pwm_mode = r.mode_polarity_select[3:2] == MPOL_PWM;
	// Sleep stops the whole time base; the postscaler is not modelled
	assign tick = r.timer_run && !sleep_in;
	assign boundary = tick && r.sub >= epwm_sub_max(r.timer_prescale_select)
		&& r.base_timer_count == r.period_limit;
	assign rd_cycle = wb_cyc_in && wb_stb_in && !r.ack;
	assign wr = rd_cycle && wb_we_in && wb_sel_in[0];

	always_comb begin
		next_r = r;
		nxt_tb = '0;
		on = '0;
		pol_low = '0;
		db_done = 1'b0;
		// Time base advance
		if (tick) begin
			// A smaller prescale can leave the sub-count past its new end;
			// wrapping at once avoids a stall of up to 64 clocks
			if (r.sub >= epwm_sub_max(r.timer_prescale_select)) begin
				next_r.sub = '0;
				if (boundary) begin
					next_r.base_timer_count = '0;
				end else begin
					next_r.base_timer_count = r.base_timer_count + 1'b1;
				end
			end else begin
				next_r.sub = r.sub + 6'h01;
			end
		end
		nxt_tb = {next_r.base_timer_count,
			epwm_low_bits(next_r.sub, r.timer_prescale_select)};
		if (boundary) begin
			next_r.duty_active = r.duty_buffer_low;
			next_r.duty_latch = r.duty_lsb;
			// A zero duty never raises the pin
			next_r.raw = {r.duty_buffer_low, r.duty_lsb} != '0;
			next_r.timer_match_flag = 1'b1;
			if (pwm_mode) begin
				next_r.started = 1'b1;
			end
		end else if (tick && nxt_tb == {r.duty_active, r.duty_latch}) begin
			// Duty beyond the period never matches and the pin holds
			next_r.raw = 1'b0;
		end
		if (!pwm_mode) begin
			next_r.started = 1'b0;
		end
		// Dead band: one shared counter, restarted on every waveform edge
		if (next_r.raw != r.raw) begin
			next_r.db_left = r.output_mode_select == OM_HALF ?
				r.dead_band_count : '0;
		end else if (tick && r.db_left != '0 && r.sub[1:0] == INSTR_LAST) begin
			next_r.db_left = r.db_left - 1'b1;
		end
		db_done = next_r.db_left == '0;
		// Register writes
		if (wr) begin
			unique case (wb_adr_in)
				REG_PERIOD: next_r.period_limit = wb_dat_in[TIMER_W-1:0];
				REG_TIMER: begin
					if (!sleep_in) begin
						next_r.base_timer_count = wb_dat_in[TIMER_W-1:0];
					end
				end
				REG_DUTY_BUF: next_r.duty_buffer_low = wb_dat_in[TIMER_W-1:0];
				REG_DUTY_ACT: begin
					if (!pwm_mode) begin
						next_r.duty_active = wb_dat_in[TIMER_W-1:0];
					end
				end
				REG_CONTROL: begin
					next_r.output_mode_select =
						wb_dat_in[CTL_OMODE_LSB +: 2];
					next_r.duty_lsb = wb_dat_in[CTL_DLSB_LSB +: 2];
					next_r.mode_polarity_select = wb_dat_in[CTL_MPOL_LSB +: 4];
				end
				REG_DEAD_BAND: next_r.dead_band_count = wb_dat_in[DB_W-1:0];
				REG_TIMER_CTL: begin
					next_r.timer_run = wb_dat_in[TCTL_RUN_BIT];
					next_r.timer_prescale_select = wb_dat_in[TCTL_PS_LSB +: 2];
				end
				REG_STATUS: begin
					// Write one clears; a same-cycle period end wins
					if (wb_dat_in[STAT_FLAG_BIT] && !boundary) begin
						next_r.timer_match_flag = 1'b0;
					end
				end
				REG_PIN_DIR: next_r.pin_direction = wb_dat_in[3:0];
				default: begin
				end
			endcase
		end
		// Read data and single-cycle acknowledge
		next_r.ack = rd_cycle;
		next_r.rdata = '0;
		if (rd_cycle && !wb_we_in) begin
			unique case (wb_adr_in)
				REG_PERIOD: next_r.rdata = r.period_limit;
				REG_TIMER: next_r.rdata = r.base_timer_count;
				REG_DUTY_BUF: next_r.rdata = r.duty_buffer_low;
				REG_DUTY_ACT: next_r.rdata = r.duty_active;
				REG_CONTROL: next_r.rdata = {r.output_mode_select, r.duty_lsb,
					r.mode_polarity_select};
				REG_DEAD_BAND: next_r.rdata = {1'b0, r.dead_band_count};
				REG_TIMER_CTL: next_r.rdata = {5'h00, r.timer_run,
					r.timer_prescale_select};
				REG_STATUS: next_r.rdata = {7'h00, r.timer_match_flag};
				REG_PIN_DIR: next_r.rdata = {4'h0, r.pin_direction};
				default: next_r.rdata = '0;
			endcase
		end
		// Output steering: "on" means the pin sits at its active level
		unique case (next_r.output_mode_select)
			OM_SINGLE: on[PIN_A] = next_r.raw;
			OM_HALF: begin
				on[PIN_A] = next_r.raw && db_done;
				on[PIN_B] = !next_r.raw && db_done;
			end
			OM_FULL_FWD: begin
				on[PIN_A] = 1'b1;
				on[PIN_D] = next_r.raw;
			end
			OM_FULL_REV: begin
				on[PIN_C] = 1'b1;
				on[PIN_B] = next_r.raw;
			end
		endcase
		// No pin goes to its active level before the first full period
		if (!next_r.started) begin
			on = '0;
		end
		pol_low[PIN_A] = next_r.mode_polarity_select[MPOL_AC_LOW];
		pol_low[PIN_C] = next_r.mode_polarity_select[MPOL_AC_LOW];
		pol_low[PIN_B] = next_r.mode_polarity_select[MPOL_BD_LOW];
		pol_low[PIN_D] = next_r.mode_polarity_select[MPOL_BD_LOW];
		used = epwm_pins_used(next_r.output_mode_select);
		if (!sleep_in) begin
			for (int i = 0; i < 4; i++) begin
				// Drive only claimed pins set as outputs, in PWM mode
				next_r.oe[i] = (next_r.mode_polarity_select[3:2] == MPOL_PWM)
					&& used[i]
					&& !next_r.pin_direction[i];
				next_r.level[i] = next_r.oe[i] ?
					on[i] ^ pol_low[i] : 1'b0;
			end
		end
	end

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			r <= '0;
			r.period_limit <= PERIOD_RST;
			r.pin_direction <= PIN_DIR_RST;
		end else begin
			r <= next_r;
		end
	end

	assign wb_dat_out = {{(WB_DW - 8){1'b0}}, r.rdata};
	assign wb_ack_out = r.ack;
	assign pwm_level_out = r.level;
	assign pwm_oe_out = r.oe;

	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (sys_rst_in);

	a_ack_one_cycle: assert property (r.ack |=> !r.ack)
		else $error("ack held longer than one cycle");
	a_ack_answer: assert property (wb_cyc_in && wb_stb_in && !r.ack |=> r.ack)
		else $error("request not acknowledged next cycle");
	a_period_wrap: assert property (boundary |=> r.base_timer_count == '0
		&& r.timer_match_flag)
		else $error("count not cleared at period end");
	a_duty_copy: assert property (boundary |=>
		r.duty_active == $past(r.duty_buffer_low))
		else $error("duty not transferred at period end");
	a_duty_readonly: assert property ($changed(r.duty_active)
		&& $past(pwm_mode) |-> $past(boundary))
		else $error("active duty changed outside period end in PWM");
	a_sleep_freeze: assert property (sleep_in |=>
		$stable(r.base_timer_count) && $stable(r.level))
		else $error("timer or pins moved during sleep");
	a_reset_input: assert property (disable iff (1'b0)
		sys_rst_in |=> r.oe == '0 && r.level == '0)
		else $error("pins driven after reset");
	a_ctrl_release: assert property (r.mode_polarity_select == '0
		&& !$past(sleep_in) |-> r.oe == '0)
		else $error("pins driven with control cleared");
	a_unused_idle: assert property (r.output_mode_select == OM_SINGLE
		&& !$past(sleep_in) |-> r.oe[3:1] == '0)
		else $error("unused pin driven in single mode");
	a_fwd_a_active: assert property (r.output_mode_select == OM_FULL_FWD
		&& r.started && r.oe[PIN_A] && !$past(sleep_in)
		|-> r.level[PIN_A] == !r.mode_polarity_select[MPOL_AC_LOW])
		else $error("forward mode A not active");
	a_no_early: assert property (!r.started && !$past(sleep_in)
		&& r.oe[PIN_A] |-> r.level[PIN_A] == r.mode_polarity_select[MPOL_AC_LOW])
		else $error("output active before first period");
	// Output stage checks for half and full bridges and pins, with time base, sleep, flag and duty checks
	a_dead_band_off: assert property (
		r.output_mode_select == OM_HALF && r.db_left != '0 && r.started
		&& r.oe[1:0] == 2'h3 && !$past(sleep_in)
		|-> r.level[PIN_A] == r.mode_polarity_select[MPOL_AC_LOW]
		&& r.level[PIN_B] == r.mode_polarity_select[MPOL_BD_LOW])
		else $error("half bridge output active inside dead band");
	a_half_complement: assert property (
		r.output_mode_select == OM_HALF && r.db_left == '0 && r.started
		&& r.oe[1:0] == 2'h3 && !$past(sleep_in)
		|-> (r.level[PIN_A] ^ r.mode_polarity_select[MPOL_AC_LOW])
		!= (r.level[PIN_B] ^ r.mode_polarity_select[MPOL_BD_LOW]))
		else $error("half bridge outputs not complementary");
	a_fall_at_duty: assert property (tick && !boundary
		&& nxt_tb == {r.duty_active, r.duty_latch} |=> !r.raw)
		else $error("pin not cleared at duty match");
	a_rise_at_wrap: assert property (boundary
		&& {r.duty_buffer_low, r.duty_lsb} != '0 |=> r.raw)
		else $error("pin not set at period start");
	a_sleep_phase: assert property (sleep_in |=>
		$stable(r.sub) && $stable(r.raw))
		else $error("time base phase moved during sleep");
	a_start_clear: assert property (!pwm_mode |=> !r.started)
		else $error("start state kept outside PWM mode");
	a_dir_input: assert property (!$past(sleep_in)
		|-> (r.oe & r.pin_direction) == 4'h0)
		else $error("pin set as input is driven");
	a_idle_low: assert property ((r.level & ~r.oe) == 4'h0)
		else $error("level shown on a pin not driven");
	a_flag_clear: assert property (wr && wb_adr_in == REG_STATUS
		&& wb_dat_in[STAT_FLAG_BIT] && !boundary |=> !r.timer_match_flag)
		else $error("period flag not cleared by write one");
	a_duty_hold: assert property (!boundary
		&& !(wr && wb_adr_in == REG_DUTY_ACT) |=> $stable(r.duty_active))
		else $error("active duty changed between period ends");
	a_fwd_bc_off: assert property (
		r.output_mode_select == OM_FULL_FWD && r.started
		&& r.oe[PIN_B] && r.oe[PIN_C] && !$past(sleep_in)
		|-> r.level[PIN_B] == r.mode_polarity_select[MPOL_BD_LOW]
		&& r.level[PIN_C] == r.mode_polarity_select[MPOL_AC_LOW])
		else $error("forward mode B or C not inactive");
	a_rev_c_active: assert property (
		r.output_mode_select == OM_FULL_REV && r.started
		&& r.oe[PIN_C] && !$past(sleep_in)
		|-> r.level[PIN_C] == !r.mode_polarity_select[MPOL_AC_LOW])
		else $error("reverse mode C not active");
	a_rev_ad_off: assert property (
		r.output_mode_select == OM_FULL_REV && r.started
		&& r.oe[PIN_A] && r.oe[PIN_D] && !$past(sleep_in)
		|-> r.level[PIN_A] == r.mode_polarity_select[MPOL_AC_LOW]
		&& r.level[PIN_D] == r.mode_polarity_select[MPOL_BD_LOW])
		else $error("reverse mode A or D not inactive");

	c_period_end: cover property (boundary && pwm_mode);
	c_half_dead: cover property (r.output_mode_select == OM_HALF
		&& r.db_left != '0 && r.started);
	c_rev_run: cover property (r.output_mode_select == OM_FULL_REV
		&& r.started && r.oe == 4'hf);
	c_sleep_hold: cover property (sleep_in && r.started);
	c_fwd_run: cover property (r.output_mode_select == OM_FULL_FWD
		&& r.started && r.oe == 4'hf);
endmodule : epwm_gen

/* File: logic/epwm_pkg.sv */
// Register map, field layout and encodings of the enhanced PWM generator
package epwm_pkg;
	localparam int WB_AW = 8;
	localparam int WB_DW = 32;
	// Register byte offsets
	localparam logic [7:0] REG_PERIOD = 8'h00;
	localparam logic [7:0] REG_TIMER = 8'h04;
	localparam logic [7:0] REG_DUTY_BUF = 8'h08;
	localparam logic [7:0] REG_DUTY_ACT = 8'h0c;
	localparam logic [7:0] REG_CONTROL = 8'h10;
	localparam logic [7:0] REG_DEAD_BAND = 8'h14;
	localparam logic [7:0] REG_TIMER_CTL = 8'h18;
	localparam logic [7:0] REG_STATUS = 8'h1c;
	localparam logic [7:0] REG_PIN_DIR = 8'h20;
	// Control register fields
	localparam int CTL_OMODE_LSB = 6;
	localparam int CTL_DLSB_LSB = 4;
	localparam int CTL_MPOL_LSB = 0;
	// Timer control and status fields
	localparam int TCTL_RUN_BIT = 2;
	localparam int TCTL_PS_LSB = 0;
	localparam int STAT_FLAG_BIT = 0;
	// Reset values
	localparam logic [7:0] PERIOD_RST = 8'hff;
	localparam logic [3:0] PIN_DIR_RST = 4'hf;
	// Output mode encodings
	localparam logic [1:0] OM_SINGLE = 2'h0;
	localparam logic [1:0] OM_FULL_FWD = 2'h1;
	localparam logic [1:0] OM_HALF = 2'h2;
	localparam logic [1:0] OM_FULL_REV = 2'h3;
	// Mode/polarity: upper bits 11 select PWM, bit 1 A/C low, bit 0 B/D low
	localparam logic [1:0] MPOL_PWM = 2'h3;
	localparam int MPOL_AC_LOW = 1;
	localparam int MPOL_BD_LOW = 0;
	// Prescale encodings: 00 1:1, 01 1:4, 1x 1:16
	localparam logic [1:0] PS_1 = 2'h0;
	localparam logic [1:0] PS_4 = 2'h1;
	// Oscillator periods per instruction cycle and per-prescale sub-count ends
	localparam int OSC_PER_INSTR = 4;
	localparam logic [5:0] SUB_MAX_1 = 6'(OSC_PER_INSTR * 1 - 1);
	localparam logic [5:0] SUB_MAX_4 = 6'(OSC_PER_INSTR * 4 - 1);
	localparam logic [5:0] SUB_MAX_16 = 6'(OSC_PER_INSTR * 16 - 1);
	localparam logic [1:0] INSTR_LAST = 2'(OSC_PER_INSTR - 1);
	localparam int DB_W = 7;
	localparam int PIN_A = 0;
	localparam int PIN_B = 1;
	localparam int PIN_C = 2;
	localparam int PIN_D = 3;
endpackage : epwm_pkg

/* File: sim/epwm_load.sv */
// Far-side model: pulled-down switch inputs on the four output pins
`timescale 1ns/100ps
module epwm_load (
	input wire logic [3:0] level_in,
	input wire logic [3:0] oe_in,
	output logic [3:0] pin_out
);
	// A released pin falls to its pull-down, so the switch stays off
	assign pin_out = level_in & oe_in;
endmodule : epwm_load

/* File: sim/testbench.sv */
// Self-checking bench for the enhanced PWM generator
`timescale 1ns/100ps
module testbench;
	import epwm_pkg::*;
	// Active cycles per pin in 16 cycles, duty 2 of 8; -1 = not driven
	localparam int ACT[4][4] = '{'{4, -1, -1, -1}, '{16, 0, 0, 4},
		'{4, 12, -1, -1}, '{0, 4, 16, 0}};
	localparam logic [3:0] OEM[4] = '{4'h1, 4'hf, 4'h3, 4'hf};
	logic mclk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic sleep_in = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [3:0] sel = 4'hf;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic ack;
	logic [3:0] lvl;
	logic [3:0] oe;
	logic [3:0] pin;
	logic [31:0] rd;
	logic [31:0] t0;
	int miscompares = 0;
	int tests_run = 0;
	int cycles = 0;
	int hi[4];
	int rises;
	always #10 mclk_in = ~mclk_in;
	epwm_gen i_epwm_gen (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
		.sleep_in(sleep_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
		.wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
		.wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
		.pwm_level_out(lvl), .pwm_oe_out(oe));
	epwm_load i_epwm_load (.level_in(lvl), .oe_in(oe), .pin_out(pin));
	task close_out;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : close_out
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %0h want %0h", $time, got, exp);
		end
	endtask : chk
	task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_in);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h0, d};
		@(posedge mclk_in);
		while (ack !== 1'b1) @(posedge mclk_in);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : xfer
	task wr(input logic [7:0] a, input logic [7:0] d);
		xfer(1'b1, a, d);
	endtask : wr
	task rc(input logic [7:0] a, input logic [7:0] e);
		xfer(1'b0, a, 8'h00);
		chk(rd, {24'h0, e});
	endtask : rc
	// Window counts do not depend on where the window starts in a period
	task obs(input int n);
		logic [3:0] pv;
		@(negedge mclk_in);
		pv = pin;
		hi = '{default: 0};
		rises = 0;
		repeat (n) begin
			@(negedge mclk_in);
			for (int p = 0; p < 4; p++) hi[p] += (pin[p] === 1'b1);
			rises += (pin[0] === 1'b1 && pv[0] === 1'b0);
			pv = pin;
		end
	endtask : obs
	function automatic int exp_hi(input int m, input int q, input int p);
		int a;
		a = ACT[m][p];
		if (a < 0) return 0;
		return q[p % 2 ? 0 : 1] ? 16 - a : a;
	endfunction : exp_hi
	always @(posedge mclk_in) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			close_out;
		end
	end
	initial begin
		repeat (6) @(posedge mclk_in);
		sys_rst_in <= 1'b0;
		rc(REG_PERIOD, PERIOD_RST);
		rc(REG_PIN_DIR, {4'h0, PIN_DIR_RST});
		rc(REG_CONTROL, 8'h00);
		rc(8'h24, 8'h00);
		sel <= 4'he;
		wr(REG_DEAD_BAND, 8'h11);
		sel <= 4'hf;
		rc(REG_DEAD_BAND, 8'h00);
		@(negedge mclk_in);
		chk(oe, 4'h0);
		$display("test reset done");
		wr(REG_PERIOD, 8'h01);
		wr(REG_CONTROL, {OM_SINGLE, 2'h0, MPOL_PWM, 2'h0});
		wr(REG_DUTY_BUF, 8'h01);
		wr(REG_STATUS, 8'h01);
		wr(REG_TIMER_CTL, 8'h04);
		do xfer(1'b0, REG_STATUS, 8'h00); while (rd[0] !== 1'b1);
		wr(REG_PIN_DIR, 8'h00);
		for (int s = 0; s < 3; s++) begin
			wr(REG_TIMER_CTL, 8'h04 | 8'(s));
			repeat (16 << (2 * s)) @(negedge mclk_in);
			obs(16 << (2 * s));
			chk(hi[0], 8 << (2 * s));
			chk(rises, 2);
		end
		$display("test period done");
		wr(REG_TIMER_CTL, 8'h04);
		wr(REG_DUTY_BUF, 8'h00);
		repeat (16) @(negedge mclk_in);
		obs(16);
		chk(hi[0], 0);
		wr(REG_DUTY_BUF, 8'h10);
		repeat (16) @(negedge mclk_in);
		obs(16);
		chk(hi[0], 16);
		wr(REG_DUTY_ACT, 8'h55);
		rc(REG_DUTY_ACT, 8'h10);
		sleep_in <= 1'b1;
		xfer(1'b0, REG_TIMER, 8'h00);
		t0 = rd;
		obs(40);
		chk(rises, 0);
		chk(hi[0] % 40, 0);
		rc(REG_TIMER, t0[7:0]);
		sleep_in <= 1'b0;
		$display("test duty and sleep done");
		wr(REG_DUTY_BUF, 8'h00);
		for (int m = 0; m < 4; m++) begin
			for (int q = 0; q < 4; q++) begin
				wr(REG_CONTROL, {2'(m), 2'h2, MPOL_PWM, 2'(q)});
				repeat (16) @(negedge mclk_in);
				chk(oe, OEM[m]);
				obs(16);
				for (int p = 0; p < 4; p++) chk(hi[p], exp_hi(m, q, p));
			end
		end
		$display("test modes done");
		wr(REG_PERIOD, 8'h03);
		wr(REG_DUTY_BUF, 8'h02);
		for (int d = 1; d < 4; d += 2) begin
			wr(REG_DEAD_BAND, 8'(d));
			wr(REG_CONTROL, {OM_HALF, 2'h0, MPOL_PWM, 2'h0});
			repeat (32) @(negedge mclk_in);
			obs(32);
			chk(hi[0], d == 1 ? 8 : 0);
			chk(hi[1], d == 1 ? 8 : 0);
		end
		wr(REG_CONTROL, 8'h00);
		repeat (2) @(negedge mclk_in);
		chk(oe, 4'h0);
		wr(REG_CONTROL, {OM_SINGLE, 2'h0, MPOL_PWM, 2'h0});
		@(posedge mclk_in);
		sys_rst_in <= 1'b1;
		repeat (2) @(negedge mclk_in);
		chk(oe, 4'h0);
		@(posedge mclk_in);
		sys_rst_in <= 1'b0;
		rc(REG_PIN_DIR, 8'h0f);
		rc(REG_PERIOD, 8'hff);
		$display("test dead band and release done");
		close_out;
	end
endmodule : testbench
